// ==== design/flash_device.sv ====
// Purpose: device end, status write, protection and array reads
// Assumes: link logic runs on serial_clock, commit on sys_clk
// Notes: link registers are quiet while select is high, so the
//        sys_clk side reads them after the synchronised select rise
`timescale 1ns/10ps
module flash_device #(
    parameter int ADDR_W = 20,
    parameter int MEM_AW = 4,
    parameter int SWT_CYCLES = flash_pkg::SWT_CYC,
    parameter int PROG_CYCLES = flash_pkg::PROG_CYC,
    parameter int ERASE_CYCLES = flash_pkg::ERASE_CYC
) (
    flash_link_if.dev link, // flash pins
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic clk_en, // freezes sys_clk state when low
    output logic [7:0] status_out, // status byte
    output logic [7:0] config_out, // configuration byte
    output logic hw_protect_out, // hardware protect mode
    output logic busy_out // self-timed cycle running
);
    localparam int DEPTH = 1 << MEM_AW;

    // -------------------------------------------------
    // link side, rising edge: shift in frame
    // -------------------------------------------------
    logic first_r;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] byte_in;
    logic [7:0] op_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0] b1_r, b2_r, b4_r;
    logic [7:0] stat_m_r, stat_s_r;

    // set by select high, so the next edge starts a frame
    always_ff @(posedge link.serial_clock or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    assign cnt_nxt = first_r ? 7'h01 : ((cnt_r == flash_pkg::CNT_MAX) ? cnt_r : cnt_r + 7'h01);
    assign byte_in = {sh_r[6:0], link.io0};

    // address and data sampled on rising edges
    always_ff @(posedge link.serial_clock) begin
        sh_r <= byte_in;
        cnt_r <= cnt_nxt;
        if (cnt_nxt == flash_pkg::CNT_OP) begin
            op_r <= byte_in;
        end
        if (cnt_nxt > flash_pkg::CNT_OP && cnt_nxt <= flash_pkg::CNT_ADDR) begin
            addr_r <= {addr_r[ADDR_W-2:0], link.io0};
        end
        if (cnt_nxt == flash_pkg::CNT_WR1) begin
            b1_r <= byte_in;
        end
        if (cnt_nxt == flash_pkg::CNT_WR2) begin
            b2_r <= byte_in;
        end
        if (cnt_nxt == flash_pkg::CNT_DUMMY) begin
            b4_r <= byte_in;
        end
    end

    // status byte into the link domain, each bit two flops
    always_ff @(posedge link.serial_clock) begin
        stat_m_r <= status_out;
        stat_s_r <= stat_m_r;
    end

    // -------------------------------------------------
    // link side, falling edge: drive read data
    // -------------------------------------------------
    logic [6:0] start_cnt;
    logic dual, go;
    logic [2:0] ph_r;
    logic started_r, oe1_r, oe0_r;
    logic [7:0] out_sh_r;
    logic [7:0] cur;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [ADDR_W-1:0] base;
    logic io1_r, io0_r;
    logic [7:0] mem [DEPTH];

    // rising edge count after which data is driven out
    always_comb begin
        case (op_r)
            flash_pkg::OP_READ: start_cnt = flash_pkg::CNT_ADDR;
            flash_pkg::OP_FAST: start_cnt = flash_pkg::CNT_DUMMY;
            flash_pkg::OP_DUAL: start_cnt = flash_pkg::CNT_DUMMY;
            flash_pkg::OP_RDST: start_cnt = flash_pkg::CNT_OP;
            default: start_cnt = 7'h00;
        endcase
    end

    assign dual = (op_r == flash_pkg::OP_DUAL);
    // fast and dual reads refused while a cycle runs
    assign go = !first_r && start_cnt != 7'h00 && cnt_r >= start_cnt &&
        !((op_r == flash_pkg::OP_FAST || dual) && stat_s_r[flash_pkg::SR_BUSY]);
    assign base = started_r ? rd_addr_r : addr_r;
    assign cur = (ph_r != 3'h0) ? out_sh_r :
        ((op_r == flash_pkg::OP_RDST) ? stat_s_r : mem[base[MEM_AW-1:0]]);

    // enables and phase, released at once by select high
    always_ff @(negedge link.serial_clock or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            oe1_r <= 1'b1;
            oe0_r <= 1'b1;
            ph_r <= 3'h0;
            started_r <= 1'b0;
        end else if (go) begin
            oe1_r <= 1'b0;
            oe0_r <= !dual;
            ph_r <= (ph_r == (dual ? 3'h3 : 3'h7)) ? 3'h0 : ph_r + 3'h1;
            started_r <= 1'b1;
        end
    end

    // data bits driven on falling edges, msb first
    always_ff @(negedge link.serial_clock) begin
        if (go) begin
            io1_r <= cur[7];
            io0_r <= cur[6];
            out_sh_r <= dual ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};
            if (ph_r == 3'h0) begin
                rd_addr_r <= base + ADDR_W'(1);
            end
        end
    end

    assign link.dev_io1 = io1_r;
    assign link.dev_io1_oe_n = oe1_r;
    assign link.dev_io0 = io0_r;
    assign link.dev_io0_oe_n = oe0_r;

    // -------------------------------------------------
    // sys_clk side: commit commands at select rise
    // -------------------------------------------------
    logic cs_m, cs_s, cs_q, wp_m, wp_s;
    logic rise, new_cmd;
    logic run_r, wen_r, lock_r, quad_r, bot_r, hwp_r;
    logic [3:0] bp_r;
    logic [15:0] busy_r;
    logic wr_len_ok, wr_go, prog_go, prog_prot, erase_go;

    // protected when the index falls in the block protect region
    function automatic logic in_region(input logic [MEM_AW-1:0] idx, input logic [3:0] bp, input logic tb);
        if (bp == 4'h0) begin
            in_region = 1'b0;
        end else if (tb) begin
            in_region = int'(idx) < int'(bp);
        end else begin
            in_region = int'(idx) >= DEPTH - int'(bp);
        end
    endfunction : in_region

    // select and protect pin synchronisers
    always_ff @(posedge sys_clk) begin
        cs_m <= link.chip_select_n;
        cs_s <= cs_m;
        wp_m <= link.write_protect_n_io2;
        wp_s <= wp_m;
    end

    assign rise = cs_s && !cs_q;
    assign new_cmd = rise && cnt_r >= flash_pkg::CNT_OP;
    assign wr_len_ok = (cnt_r == flash_pkg::CNT_WR1) || (cnt_r == flash_pkg::CNT_WR2);
    assign wr_go = new_cmd && op_r == flash_pkg::OP_WST && wen_r && !run_r &&
        !hwp_r && wr_len_ok;
    assign prog_go = new_cmd && op_r == flash_pkg::OP_PROG && wen_r && !run_r &&
        cnt_r >= flash_pkg::CNT_DUMMY;
    assign prog_prot = in_region(addr_r[MEM_AW-1:0], bp_r, bot_r);
    assign erase_go = new_cmd && op_r == flash_pkg::OP_CERASE && wen_r && !run_r &&
        cnt_r == flash_pkg::CNT_OP;

    // command commit, protection and self-timed cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cs_q <= 1'b1;
            run_r <= 1'b0;
            wen_r <= 1'b0;
            lock_r <= 1'b0;
            quad_r <= 1'b0;
            bp_r <= 4'h0;
            bot_r <= 1'b0;
            hwp_r <= 1'b0;
            busy_r <= 16'h0000;
        end else if (clk_en) begin
            cs_q <= cs_s;
            // entered in either order, left only by pin high
            hwp_r <= lock_r && !wp_s;
            if (busy_r == 16'h0001) begin
                run_r <= 1'b0;
                wen_r <= 1'b0;
            end
            if (busy_r != 16'h0000) begin
                busy_r <= busy_r - 16'h0001;
            end
            if (wr_go) begin
                // latch and busy bits are not taken from data
                lock_r <= b1_r[flash_pkg::SR_LOCK];
                quad_r <= b1_r[flash_pkg::SR_QUAD];
                bp_r <= b1_r[flash_pkg::SR_BP_LO +: 4];
                if (cnt_r == flash_pkg::CNT_WR2) begin
                    bot_r <= bot_r | b2_r[flash_pkg::CR_BOT];
                end
                run_r <= 1'b1;
                busy_r <= 16'(SWT_CYCLES);
            end else if (prog_go && prog_prot) begin
                wen_r <= 1'b0;
            end else if (prog_go) begin
                run_r <= 1'b1;
                busy_r <= 16'(PROG_CYCLES);
            end else if (erase_go && bp_r != 4'h0) begin
                wen_r <= 1'b0;
            end else if (erase_go) begin
                run_r <= 1'b1;
                busy_r <= 16'(ERASE_CYCLES);
            end
            if (new_cmd && op_r == flash_pkg::OP_WEN && cnt_r == flash_pkg::CNT_OP) begin
                wen_r <= 1'b1;
            end
        end
    end

    // array storage, written by accepted program and erase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= flash_pkg::ERASED;
            end
        end else if (clk_en) begin
            if (prog_go && !prog_prot) begin
                mem[addr_r[MEM_AW-1:0]] <= mem[addr_r[MEM_AW-1:0]] & b4_r;
            end else if (erase_go && bp_r == 4'h0) begin
                for (int i = 0; i < DEPTH; i++) begin
                    mem[i] <= flash_pkg::ERASED;
                end
            end
        end
    end

    assign status_out = {lock_r, quad_r, bp_r, wen_r, run_r};
    assign config_out = {4'h0, bot_r, 3'h0};
    assign hw_protect_out = hwp_r;
    assign busy_out = run_r;
endmodule : flash_device

// ==== design/flash_pkg.sv ====
// Purpose: shared constants for the serial flash device and host ends
// Assumes: mode 0 framing, opcode and address sent msb first on io0
// Notes: times in ns, cycle counts derived from the 100 MHz sys_clk
package flash_pkg;
    // ---------------------------------------------
    // opcodes
    // ---------------------------------------------
    localparam logic [7:0] OP_WEN = 8'h06;
    localparam logic [7:0] OP_WST = 8'h01;
    localparam logic [7:0] OP_RDST = 8'h05;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DUAL = 8'h3B;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_CERASE = 8'h60;
    // ---------------------------------------------
    // register fields and reset values
    // ---------------------------------------------
    localparam int SR_BUSY = 0;
    localparam int SR_WEN = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_QUAD = 6;
    localparam int SR_LOCK = 7;
    localparam int CR_BOT = 3;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] ERASED = 8'hFF;
    // ---------------------------------------------
    // frame bit counts (rising edges since select fell)
    // ---------------------------------------------
    localparam logic [6:0] CNT_OP = 7'h08;
    localparam logic [6:0] CNT_WR1 = 7'h10;
    localparam logic [6:0] CNT_WR2 = 7'h18;
    localparam logic [6:0] CNT_ADDR = 7'h20;
    localparam logic [6:0] CNT_DUMMY = 7'h28;
    localparam logic [6:0] CNT_MAX = 7'h7F;
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int SYS_PERIOD_NS = 10;
    localparam int SWT_NS = 40000;
    localparam int PROG_NS = 20000;
    localparam int ERASE_NS = 40000;
    localparam int SWT_CYC = (SWT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int PROG_CYC = (PROG_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int ERASE_CYC = (ERASE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int HALF_SCK = 4;
endpackage : flash_pkg

// ==== design/flash_link_if.sv ====
// Purpose: pins between the flash host and the flash device
// Assumes: each io line resolved here from drivers and enables
// Notes: undriven io lines read high, as with a pull-up
`timescale 1ns/10ps
interface flash_link_if;
    logic chip_select_n;
    logic serial_clock;
    logic write_protect_n_io2;
    logic host_io0;
    logic host_io0_oe_n;
    logic dev_io0;
    logic dev_io0_oe_n;
    logic dev_io1;
    logic dev_io1_oe_n;
    logic io0;
    logic io1;

    // wire level from the enables
    assign io0 = !dev_io0_oe_n ? dev_io0 : (!host_io0_oe_n ? host_io0 : 1'b1);
    assign io1 = !dev_io1_oe_n ? dev_io1 : 1'b1;

    modport host (
        output chip_select_n, serial_clock, write_protect_n_io2,
        output host_io0, host_io0_oe_n,
        input io0, io1
    );
    modport dev (
        input chip_select_n, serial_clock, write_protect_n_io2, io0,
        output dev_io0, dev_io0_oe_n, dev_io1, dev_io1_oe_n
    );
endinterface : flash_link_if

// ==== design/flash_host.sv ====
// Purpose: host end, frames commands and collects read bytes
// Assumes: serial_clock made by dividing sys_clk, mode 0
// Notes: HALF_CYC must be 4 or more for the input synchroniser
`timescale 1ns/10ps
module flash_host #(
    parameter int HALF_CYC = flash_pkg::HALF_SCK,
    parameter int WP_HOLD_CYC = flash_pkg::SWT_CYC
) (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic clk_en, // freezes state when low
    flash_link_if.host link, // flash pins
    input wire logic req_valid, // start a frame
    input wire logic [6:0] req_tx_len, // bits sent on io0
    input wire logic [47:0] req_tx_bits, // msb first
    input wire logic [7:0] req_rx_bytes, // bytes to read
    input wire logic req_dual, // read two bits a clock
    input wire logic wp_level, // wanted protect pin level
    output logic req_ready, // idle, takes a request
    output logic rd_valid, // one byte received
    output logic [7:0] rd_byte, // received byte
    output logic done // frame finished
);
    typedef enum logic [2:0] {H_IDLE, H_SEL, H_TX, H_RX, H_END, H_GAP} hstate_t;
    hstate_t st_r;
    logic [7:0] hc_r;
    logic tick;
    logic cs_r, sck_r, io0_r, oe_n_r, wp_r;
    logic [47:0] tx_r;
    logic [6:0] tx_left_r;
    logic [7:0] rx_left_r;
    logic dual_r, wst_r;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [2:0] rbit_r;
    logic [2:0] rbit_nxt;
    logic [15:0] hold_r;
    logic io0_m, io0_s, io1_m, io1_s;

    // status write length must be one or two data bytes after the opcode
    function automatic logic [6:0] fix_len(input logic [7:0] op, input logic [6:0] len);
        if (op == flash_pkg::OP_WST && len != flash_pkg::CNT_WR1 && len != flash_pkg::CNT_WR2) begin
            fix_len = flash_pkg::CNT_WR1;
        end else begin
            fix_len = len;
        end
    endfunction : fix_len

    assign tick = (hc_r == 8'(HALF_CYC - 1));
    assign sh_nxt = dual_r ? {sh_r[5:0], io1_s, io0_s} : {sh_r[6:0], io1_s};
    assign rbit_nxt = rbit_r + (dual_r ? 3'h2 : 3'h1);

    // pin input synchronisers
    always_ff @(posedge sys_clk) begin
        io0_m <= link.io0;
        io0_s <= io0_m;
        io1_m <= link.io1;
        io1_s <= io1_m;
    end

    // half period divider
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (clk_en && (st_r == H_IDLE || tick))) begin
            hc_r <= 8'h00;
        end else if (clk_en) begin
            hc_r <= hc_r + 8'h01;
        end
    end

    // frame sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= H_IDLE;
            cs_r <= 1'b1;
            sck_r <= 1'b0;
            io0_r <= 1'b0;
            oe_n_r <= 1'b1;
            req_ready <= 1'b1;
            rd_valid <= 1'b0;
            rd_byte <= 8'h00;
            done <= 1'b0;
            tx_r <= 48'h0;
            tx_left_r <= 7'h00;
            rx_left_r <= 8'h00;
            dual_r <= 1'b0;
            wst_r <= 1'b0;
            sh_r <= 8'h00;
            rbit_r <= 3'h0;
        end else if (clk_en) begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            case (st_r)
                H_IDLE: begin
                    if (req_valid) begin
                        // select, first bit, opcode sent msb first
                        cs_r <= 1'b0;
                        io0_r <= req_tx_bits[47];
                        oe_n_r <= 1'b0;
                        tx_r <= {req_tx_bits[46:0], 1'b0};
                        tx_left_r <= fix_len(req_tx_bits[47:40], req_tx_len);
                        rx_left_r <= req_rx_bytes;
                        dual_r <= req_dual;
                        wst_r <= (req_tx_bits[47:40] == flash_pkg::OP_WST);
                        rbit_r <= 3'h0;
                        req_ready <= 1'b0;
                        st_r <= H_SEL;
                    end
                end
                H_SEL: begin
                    if (tick) begin
                        sck_r <= 1'b1;
                        tx_left_r <= tx_left_r - 7'h01;
                        st_r <= H_TX;
                    end
                end
                H_TX: begin
                    if (tick && sck_r) begin
                        sck_r <= 1'b0;
                        if (tx_left_r == 7'h00) begin
                            // exactly the asked bit count, then stop
                            oe_n_r <= 1'b1;
                            st_r <= (rx_left_r == 8'h00) ? H_END : H_RX;
                        end else begin
                            io0_r <= tx_r[47];
                            tx_r <= {tx_r[46:0], 1'b0};
                        end
                    end else if (tick) begin
                        sck_r <= 1'b1;
                        tx_left_r <= tx_left_r - 7'h01;
                    end
                end
                H_RX: begin
                    if (tick && !sck_r) begin
                        // sample on the rising edge
                        sck_r <= 1'b1;
                        sh_r <= sh_nxt;
                        rbit_r <= rbit_nxt;
                        if (rbit_nxt == 3'h0) begin
                            rd_valid <= 1'b1;
                            rd_byte <= sh_nxt;
                            rx_left_r <= rx_left_r - 8'h01;
                        end
                    end else if (tick) begin
                        sck_r <= 1'b0;
                        if (rx_left_r == 8'h00) begin
                            st_r <= H_END;
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        cs_r <= 1'b1;
                        st_r <= H_GAP;
                    end
                end
                default: begin
                    if (tick) begin
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // protect pin held high through a status write cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hold_r <= 16'h0000;
            wp_r <= 1'b1;
        end else if (clk_en) begin
            if (st_r == H_END && tick && wst_r) begin
                hold_r <= 16'(WP_HOLD_CYC);
            end else if (hold_r != 16'h0000) begin
                hold_r <= hold_r - 16'h0001;
            end
            wp_r <= (wst_r && st_r != H_IDLE) || hold_r != 16'h0000 || wp_level;
        end
    end

    assign link.chip_select_n = cs_r;
    assign link.serial_clock = sck_r;
    assign link.host_io0 = io0_r;
    assign link.host_io0_oe_n = oe_n_r;
    assign link.write_protect_n_io2 = wp_r;
endmodule : flash_host

// ==== test/flash_link_monitor.sv ====
// Purpose: wire checks on the link between flash host and device
// Assumes: link signals sampled on sys_clk, half period of 4 or more
// Notes: bit count and opcode are rebuilt from the wire
`timescale 1ns/10ps
module flash_link_monitor (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic chip_select_n, // select, low active
    input wire logic serial_clock, // link clock
    input wire logic write_protect_n_io2, // protect pin
    input wire logic host_io0, // host data
    input wire logic host_io0_oe_n, // host enable
    input wire logic dev_io0, // device io0 data
    input wire logic dev_io0_oe_n, // device io0 enable
    input wire logic dev_io1, // device io1 data
    input wire logic dev_io1_oe_n, // device io1 enable
    input wire logic io0 // resolved io0
);
    logic sck_d_r;
    logic [6:0] cnt_r;
    logic [7:0] op_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // delayed link clock for edge finding
    always_ff @(posedge sys_clk) sck_d_r <= serial_clock;
    // rising edges since select fell
    always_ff @(posedge sys_clk) begin
        if (chip_select_n) cnt_r <= 7'h00;
        else if (serial_clock && !sck_d_r && cnt_r != 7'h7F) cnt_r <= cnt_r + 7'h01;
    end
    // opcode from the first eight bits
    always_ff @(posedge sys_clk) begin
        if (serial_clock && !sck_d_r && !chip_select_n && cnt_r < 7'h08) op_r <= {op_r[6:0], io0};
    end
    // ------------------------------------------
    // properties
    // ------------------------------------------
    sequence s_hi2; serial_clock ##1 serial_clock; endsequence
    sequence s_wr_end; $rose(chip_select_n) && op_r == 8'h01; endsequence
    property p_release; chip_select_n |-> dev_io0_oe_n && dev_io1_oe_n; endproperty
    property p_one_drv; !dev_io0_oe_n |-> host_io0_oe_n; endproperty
    property p_sel_low; $changed(chip_select_n) |-> !serial_clock && !$past(serial_clock); endproperty
    property p_host_hold; s_hi2 |-> $stable(host_io0); endproperty
    property p_dev_hold; s_hi2 |-> $stable(dev_io0) && $stable(dev_io1); endproperty
    property p_wr_len; s_wr_end |-> cnt_r == 7'h10 || cnt_r == 7'h18; endproperty
    property p_wp_hold; !chip_select_n && op_r == 8'h01 && cnt_r >= 7'h08 |-> write_protect_n_io2; endproperty
    property p_out_late; !dev_io1_oe_n |-> cnt_r >= 7'h08; endproperty
    property p_dual; !dev_io0_oe_n |-> op_r == 8'h3B && cnt_r >= 7'h28; endproperty
    property p_fast; !dev_io1_oe_n && (op_r == 8'h0B || op_r == 8'h3B) |-> cnt_r >= 7'h28; endproperty
    property p_read; !dev_io1_oe_n && op_r == 8'h03 |-> cnt_r >= 7'h20; endproperty
    a_release: assert property (p_release) else $error("io driven while deselected");
    a_one_drv: assert property (p_one_drv) else $error("io0 driven by both");
    a_sel_low: assert property (p_sel_low) else $error("select moved with clock high");
    a_host_hold: assert property (p_host_hold) else $error("host data moved in high phase");
    a_dev_hold: assert property (p_dev_hold) else $error("device data moved in high phase");
    a_wr_len: assert property (p_wr_len) else $error("status write length");
    a_wp_hold: assert property (p_wp_hold) else $error("protect pin low in status write");
    a_out_late: assert property (p_out_late) else $error("output before opcode end");
    a_dual: assert property (p_dual) else $error("io0 output early or wrong command");
    a_fast: assert property (p_fast) else $error("fast output before dummy end");
    a_read: assert property (p_read) else $error("read output before address end");
endmodule : flash_link_monitor

// ==== test/tb.sv ====
// Purpose: bench joining flash host and flash device
// Assumes: host frames every command, wire watched by monitor
// Notes: short self-timed counts keep the run brief
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [6:0] len; logic [47:0] bits; logic [7:0] rx; logic dual; logic wp;
        logic [15:0] rd; logic [8:0] st;} row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic [6:0] req_tx_len = 7'h00;
    logic [47:0] req_tx_bits = 48'h0;
    logic [7:0] req_rx_bytes = 8'h00;
    logic req_dual = 1'b0;
    logic wp_level = 1'b1;
    logic req_ready, rd_valid, done, hw_protect_out, busy_out;
    logic [7:0] rd_byte, status_out, config_out;
    logic [15:0] got;
    int n_mismatch = 0;
    int samples_checked = 0;
    row_t rows [19];
    flash_link_if link ();
    flash_host #(.WP_HOLD_CYC(20)) flash_host_i (.sys_clk, .sys_rst, .clk_en(1'b1), .link(link), .req_valid,
        .req_tx_len, .req_tx_bits, .req_rx_bytes, .req_dual, .wp_level, .req_ready, .rd_valid, .rd_byte, .done);
    flash_device #(.SWT_CYCLES(1000), .PROG_CYCLES(20)) flash_device_i (.link(link), .sys_clk, .sys_rst,
        .clk_en(1'b1), .status_out, .config_out, .hw_protect_out, .busy_out);
    flash_link_monitor flash_link_monitor_i (.sys_clk, .sys_rst, .chip_select_n(link.chip_select_n),
        .serial_clock(link.serial_clock), .write_protect_n_io2(link.write_protect_n_io2), .host_io0(link.host_io0),
        .host_io0_oe_n(link.host_io0_oe_n), .dev_io0(link.dev_io0), .dev_io0_oe_n(link.dev_io0_oe_n),
        .dev_io1(link.dev_io1), .dev_io1_oe_n(link.dev_io1_oe_n), .io0(link.io0));
    // -----------------------------------------
    // tasks
    // -----------------------------------------
    task chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk
    // one frame, bytes collected into got
    task xfer(input row_t r);
        int k;
        got = 16'h0000;
        wp_level = r.wp;
        {req_tx_len, req_tx_bits, req_rx_bytes, req_dual} = {r.len, r.bits, r.rx, r.dual};
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (k = 0; k < 3000 && done !== 1'b1; k++) begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1) got = {got[7:0], rd_byte};
        end
        chk(done === 1'b1, "frame end");
        repeat (6) @(negedge sys_clk);
    endtask : xfer
    task idle;
        int k;
        for (k = 0; k < 2000 && busy_out !== 1'b0; k++) @(negedge sys_clk);
        chk(busy_out === 1'b0, "cycle end");
        repeat (4) @(negedge sys_clk);
    endtask : idle
    task complete_run;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // -----------------------------------------
    // stimulus
    // -----------------------------------------
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #1000000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rows[0] = '{7'h10, 48'h013F00000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[1] = '{7'h08, 48'h060000000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h002};
        rows[2] = '{7'h28, 48'h02000000A500, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[3] = '{7'h20, 48'h030FFFFF0000, 8'h02, 1'b0, 1'b1, 16'hFFA5, 9'h000};
        rows[4] = '{7'h28, 48'h0B0FFFFF0000, 8'h02, 1'b0, 1'b1, 16'hFFA5, 9'h000};
        rows[5] = '{7'h28, 48'h3B0000000000, 8'h01, 1'b1, 1'b1, 16'h00A5, 9'h000};
        rows[6] = rows[1];
        rows[7] = '{7'h10, 48'h018700000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h084};
        rows[8] = '{7'h08, 48'h060000000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h086};
        rows[9] = '{7'h28, 48'h0200000F0000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h084};
        rows[10] = '{7'h08, 48'h060000000000, 8'h00, 1'b0, 1'b0, 16'h0000, 9'h186};
        rows[11] = '{7'h08, 48'h050000000000, 8'h01, 1'b0, 1'b1, 16'h0086, 9'h086};
        rows[12] = '{7'h10, 48'h010000000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[13] = rows[1];
        rows[14] = '{7'h10, 48'h011000000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[15] = '{7'h08, 48'h050000000000, 8'h01, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[16] = '{7'h28, 48'h0B0000000000, 8'h01, 1'b0, 1'b1, 16'h0000, 9'h000};
        rows[17] = '{7'h18, 48'h011008000000, 8'h00, 1'b0, 1'b1, 16'h0000, 9'h000};
        repeat (12) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        chk({hw_protect_out, status_out, config_out, busy_out, req_ready} === 19'h00001, "reset");
        // table of ordinary frames
        for (int i = 0; i < 13; i++) begin
            xfer(rows[i]);
            idle();
            chk(got === rows[i].rd, "read data");
            chk({hw_protect_out, status_out} === rows[i].st, "status");
        end
        // polling and reads during a status write cycle
        xfer(rows[13]);
        xfer(rows[14]);
        xfer(rows[15]);
        chk(got === 16'h0013, "busy poll");
        xfer(rows[16]);
        chk(got === 16'h00FF, "fast read while busy");
        idle();
        chk(status_out === 8'h10, "after write cycle");
        // two-byte status write reaches configuration
        xfer(rows[13]);
        xfer(rows[17]);
        idle();
        chk({status_out, config_out} === 16'h1008, "config");
        complete_run();
    end
endmodule : tb
